// file: src/quad_wiper_cfg.svh
`ifndef QUAD_WIPER_CFG_SVH
`define QUAD_WIPER_CFG_SVH
// serial register address of the select/status register
`define SR_ADDR 3'h7
// status register reset value (three live bits)
`define SR_RESET 3'h0
// status field positions
`define SR_NV_EN 0
`define SR_SEL_LO 1
`define SR_SEL_HI 2
// direction bit in the slave address byte
`define SA_RW 0
// highest channel address
`define CH_LAST 3'h3
// last bit index of a byte
`define LAST_BIT 3'h7
// wiper end positions
`define WIPER_MIN 8'h00
`define WIPER_MAX 8'hff
// contents of the nonvolatile slots after reset
`define NV_INIT 8'h80
`endif

// file: src/quad_wiper_pkg.sv
package quad_wiper_pkg;
   // events seen at the link pins, one toggle each
   typedef struct packed {
      logic fall;
      logic rise;
      logic start;
      logic stop;
      logic store;
   } link_ev_t;
   // synchronised control pins
   typedef struct packed {
      logic cs_n;
      logic updn;
      logic [1:0] ds;
      logic wp_n;
      logic [2:0] hw_addr;
   } ctl_pins_t;
   typedef enum logic [3:0] {
      S_IDLE, S_DEV, S_DEV_ACK, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
   } srl_state_t;
endpackage : quad_wiper_pkg

// file: src/quad_wiper_updown_serial_control.sv
// What this block does
// - select low: up/down stepping, serial ignored; select high: serial enabled.
// - direction high steps up, low steps down.
// - pot_select 00..11 picks channel 0..3 for up/down.
// - write protect low blocks all nonvolatile writes, serial and store.
// - each position decodes one-hot to one of 256 taps.
// - zero picks the low-end tap, all ones the high-end tap.
// - four nonvolatile slots per channel, loadable into position, all readable and writable.
// - at power-up each position loads from its slot 0.
// - each SCL fall while selected steps the chosen position.
// - select rising with SCL and protect high stores position into slot 0.
// - select rising with SCL low returns to standby, no store, position kept.
// - direction may change any time while selected.
// - serial ops start with START and address byte, MSB first, slave only.
// - SDA changes only with SCL low; SDA comes up released.
// - START is SDA falling with SCL high; nothing answered before it.
// - STOP is SDA rising with SCL high; ends every transfer.
// - after eight bits transmitter releases, receiver pulls low on ninth clock.
// - address byte acked only on type id and hardware address match.
// - every written byte after the address byte is acked.
// - read: send eight bits, release, continue on ack, stop on no ack.
// - status at address 07h resets 00h: bit0 target, bits 2:1 slot.
// - address byte bit 0 high reads, low writes.
`include "quad_wiper_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module quad_wiper_updown_serial_control
   import quad_wiper_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE_ID = 4'ha // arbitrary value
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic interface_select_n_i,
   input wire logic count_direction_i,
   input wire logic [1:0] pot_select_i,
   input wire logic nv_write_protect_n_i,
   input wire logic [2:0] hw_address_pins_i,
   output logic [3:0][7:0] wiper_position_o,
   output logic [3:0][255:0] tap_sel_o
);
   ////////////////////////////////////////////////////////////////////
   // reset release, one copy per domain
   logic [1:0] crst_q;
   logic [1:0] lrst_q;
   logic rst_n;
   logic lrst_n;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) crst_q <= 2'h0;
      else crst_q <= {crst_q[0], 1'b1};
   end
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) lrst_q <= 2'h0;
      else lrst_q <= {lrst_q[0], 1'b1};
   end
   assign rst_n = crst_q[1];
   assign lrst_n = lrst_q[1];

   ////////////////////////////////////////////////////////////////////
   // link domain: pin sampling and event detection
   logic [2:0] lp1_q, lp2_q, lp3_q; // {scl, sda, select_n}
   link_ev_t ltg_q, ltg_d;
   logic bit_q, bit_d;
   logic l_fall, l_rise, l_scl, l_sda, l_psda;
   always_ff @(posedge link_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         lp1_q <= 3'h7;
         lp2_q <= 3'h7;
         lp3_q <= 3'h7;
      end else begin
         lp1_q <= {scl_i, sda_i, interface_select_n_i};
         lp2_q <= lp1_q;
         lp3_q <= lp2_q;
      end
   end
   // edges of the synchronised pins, flipped into toggles
   always_comb begin
      l_scl = lp2_q[2];
      l_sda = lp2_q[1];
      l_psda = lp3_q[1];
      l_fall = lp3_q[2] & ~l_scl;
      l_rise = ~lp3_q[2] & l_scl;
      ltg_d = ltg_q;
      bit_d = bit_q;
      ltg_d.fall = ltg_q.fall ^ l_fall;
      ltg_d.rise = ltg_q.rise ^ l_rise;
      ltg_d.start = ltg_q.start ^ (l_scl & lp3_q[2] & l_psda & ~l_sda);
      ltg_d.stop = ltg_q.stop ^ (l_scl & lp3_q[2] & ~l_psda & l_sda);
      ltg_d.store = ltg_q.store ^ (l_scl & ~lp3_q[0] & lp2_q[0]);
      if (l_rise) bit_d = l_sda; // data held stable until next rise
   end
   always_ff @(posedge link_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         ltg_q <= '0;
         bit_q <= 1'b1;
      end else begin
         ltg_q <= ltg_d;
         bit_q <= bit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // core domain: toggle and control pin synchronisers
   link_ev_t ts1_q, ts2_q, ts3_q, ev;
   ctl_pins_t cp_raw, cp1_q, cp_s;
   assign cp_raw = '{interface_select_n_i, count_direction_i, pot_select_i, nv_write_protect_n_i,
                     hw_address_pins_i};
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ts1_q <= '0;
         ts2_q <= '0;
         ts3_q <= '0;
         cp1_q <= '{1'b1, 1'b0, 2'h0, 1'b0, 3'h0};
         cp_s <= '{1'b1, 1'b0, 2'h0, 1'b0, 3'h0};
      end else begin
         ts1_q <= ltg_q;
         ts2_q <= ts1_q;
         ts3_q <= ts2_q;
         cp1_q <= cp_raw;
         cp_s <= cp1_q;
      end
   end
   assign ev = ts2_q ^ ts3_q;

   ////////////////////////////////////////////////////////////////////
   // core state: positions, slots, status and serial front end
   logic [3:0][7:0] wip_q, wip_d;
   logic [3:0][3:0][7:0] nv_q, nv_d;
   logic [2:0] sr_q, sr_d;
   srl_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] addr_q, addr_d;
   logic rw_q, rw_d, mack_q, mack_d, oe_n_q, oe_n_d, recall_q, recall_d;
   logic skip_q, skip_d; // scl fall that closes start is no data bit
   logic [7:0] rd_byte, sel_wip;
   logic [1:0] ch, slot;
   logic ld, step_up, step_dn;

   assign ch = addr_q[1:0];
   assign slot = sr_q[`SR_SEL_HI:`SR_SEL_LO];
   assign sel_wip = wip_q[cp_s.ds];
   assign step_up = ev.fall & ~cp_s.cs_n & cp_s.updn;
   assign step_dn = ev.fall & ~cp_s.cs_n & ~cp_s.updn;

   // byte returned by a serial read
   always_comb begin
      rd_byte = 8'h00;
      if (addr_q == `SR_ADDR) rd_byte = {5'h00, sr_q};
      else if (addr_q <= `CH_LAST) begin
         if (sr_q[`SR_NV_EN]) rd_byte = nv_q[ch][slot];
         else rd_byte = wip_q[ch];
      end
   end

   // next values of all core state
   always_comb begin
      wip_d = wip_q;
      nv_d = nv_q;
      sr_d = sr_q;
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      rw_d = rw_q;
      mack_d = mack_q;
      oe_n_d = oe_n_q;
      skip_d = skip_q;
      recall_d = 1'b0;
      ld = 1'b0;
      if (recall_q) begin
         for (int i = 0; i < 4; i++) wip_d[i] = nv_q[i][0];
      end else if (cp_s.cs_n == 1'b0) begin
         st_d = S_IDLE;
         oe_n_d = 1'b1;
         if (step_up && sel_wip != `WIPER_MAX) wip_d[cp_s.ds] = sel_wip + 8'h01;
         if (step_dn && sel_wip != `WIPER_MIN) wip_d[cp_s.ds] = sel_wip - 8'h01;
      end else if (ev.stop) begin
         st_d = S_IDLE;
         oe_n_d = 1'b1;
      end else if (ev.start) begin
         st_d = S_DEV;
         cnt_d = 3'h0;
         skip_d = 1'b1;
         oe_n_d = 1'b1;
      end else if (ev.rise) begin
         if (st_q == S_DEV || st_q == S_ADDR || st_q == S_WR) sh_d = {sh_q[6:0], bit_q};
         if (st_q == S_RD_ACK) mack_d = ~bit_q;
      end else if (ev.fall) begin
         cnt_d = cnt_q + 3'h1;
         case (st_q)
            S_DEV: begin
               if (skip_q) begin
                  skip_d = 1'b0;
                  cnt_d = cnt_q;
               end else if (cnt_q == `LAST_BIT) begin
                  if (sh_q[7:4] == DEV_TYPE_ID && sh_q[3:1] == cp_s.hw_addr) begin
                     oe_n_d = 1'b0;
                     st_d = S_DEV_ACK;
                     rw_d = sh_q[`SA_RW];
                  end else st_d = S_IDLE;
               end
            end
            S_DEV_ACK: begin
               oe_n_d = 1'b1;
               cnt_d = 3'h0;
               if (rw_q) ld = 1'b1;
               else st_d = S_ADDR;
            end
            S_ADDR: begin
               if (cnt_q == `LAST_BIT) begin
                  oe_n_d = 1'b0;
                  st_d = S_ADDR_ACK;
                  addr_d = sh_q[2:0];
               end
            end
            S_WR: begin
               if (cnt_q == `LAST_BIT) begin
                  oe_n_d = 1'b0;
                  st_d = S_WR_ACK;
                  if (addr_q == `SR_ADDR) sr_d = sh_q[2:0];
                  else if (addr_q <= `CH_LAST) begin
                     wip_d[ch] = sh_q;
                     if (sr_q[`SR_NV_EN] && cp_s.wp_n) nv_d[ch][slot] = sh_q;
                  end
               end
            end
            S_ADDR_ACK, S_WR_ACK: begin
               oe_n_d = 1'b1;
               cnt_d = 3'h0;
               st_d = S_WR;
            end
            S_RD: begin
               if (cnt_q == `LAST_BIT) begin
                  oe_n_d = 1'b1;
                  st_d = S_RD_ACK;
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_n_d = sh_q[6]; // open drain: release for a one
               end
            end
            S_RD_ACK: begin
               cnt_d = 3'h0;
               if (mack_q) ld = 1'b1;
               else st_d = S_IDLE;
            end
            default: cnt_d = cnt_q;
         endcase
      end
      // start a read byte, a slot read also moves the wiper
      if (ld) begin
         sh_d = rd_byte;
         oe_n_d = rd_byte[7];
         st_d = S_RD;
         if (addr_q <= `CH_LAST && sr_q[`SR_NV_EN]) wip_d[ch] = nv_q[ch][slot];
      end
      // store on select rising with SCL high
      if (ev.store && cp_s.wp_n && !recall_q) nv_d[cp_s.ds][0] = sel_wip;
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wip_q <= '0;
         nv_q <= {16{`NV_INIT}};
         sr_q <= `SR_RESET;
         st_q <= S_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         addr_q <= 3'h0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         oe_n_q <= 1'b1;
         recall_q <= 1'b1;
         skip_q <= 1'b0;
      end else begin
         wip_q <= wip_d;
         nv_q <= nv_d;
         sr_q <= sr_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         rw_q <= rw_d;
         mack_q <= mack_d;
         oe_n_q <= oe_n_d;
         recall_q <= recall_d;
         skip_q <= skip_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // tap decode, one register per channel
   logic [3:0][255:0] tap_q;
   for (genvar c = 0; c < 4; c++) begin : g_tap
      logic [255:0] tap_d;
      assign tap_d = 256'h1 << wip_q[c];
      always_ff @(posedge core_clk_i or negedge rst_n) begin
         if (!rst_n) tap_q[c] <= 256'h1;
         else tap_q[c] <= tap_d;
      end
      a_tap_onehot: assert property (@(posedge core_clk_i) disable iff (!rst_n) $onehot(tap_q[c]))
         else $error("tap select not one-hot");
      a_tap_ends: assert property (@(posedge core_clk_i) disable iff (!rst_n)
         wip_q[c] == `WIPER_MAX |=> tap_q[c][255])
         else $error("full scale not at high tap");
   end

   assign sda_o = 1'b0;
   assign sda_oe_n_o = oe_n_q;
   assign wiper_position_o = wip_q;
   assign tap_sel_o = tap_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);
   a_recall_slot0: assert property (recall_q |=> wip_q[2] == nv_q[2][0])
      else $error("power-up recall missed");
   a_step_up: assert property (step_up && !recall_q && sel_wip != `WIPER_MAX
      |=> sel_wip == $past(sel_wip) + 8'h01)
      else $error("step up wrong");
   a_sat_low: assert property (step_dn && sel_wip == `WIPER_MIN |=> sel_wip == `WIPER_MIN)
      else $error("step down wrapped");
   a_store_slot0: assert property (ev.store && cp_s.wp_n && !recall_q
      |=> nv_q[$past(cp_s.ds)][0] == $past(sel_wip))
      else $error("store missed");
   a_protect_nv: assert property (!cp_s.wp_n |=> nv_q == $past(nv_q))
      else $error("protected slot written");
   a_select_mute: assert property (!cp_s.cs_n ##1 !cp_s.cs_n |-> oe_n_q && st_q == S_IDLE)
      else $error("serial active while selected");
   a_idle_wait: assert property (st_q == S_IDLE && !ev.start |=> st_q == S_IDLE)
      else $error("left idle without start");
   a_addr_nack: assert property (cp_s.cs_n && st_q == S_DEV && ev.fall && cnt_q == `LAST_BIT
      && sh_q[3:1] != cp_s.hw_addr && !ev.stop && !ev.start |=> oe_n_q && st_q == S_IDLE)
      else $error("foreign address acked");
   a_ack_release: assert property ((st_q == S_ADDR_ACK || st_q == S_WR_ACK) && ev.fall
      && cp_s.cs_n && !ev.stop && !ev.start && !ev.rise |=> oe_n_q)
      else $error("ack not released");
   c_step: cover property (step_up ##[1:200] step_dn);
   c_store: cover property (ev.store && cp_s.wp_n);
   c_write: cover property (st_q == S_WR_ACK);
   c_read: cover property (st_q == S_RD ##[1:300] st_q == S_RD_ACK);
endmodule : quad_wiper_updown_serial_control
`default_nettype wire

// file: dv/wiper_host.sv
`timescale 1ns/1ps
`default_nettype none
// host controller model on the up/down and 2-wire pins
module wiper_host (
   input wire logic clk_i,
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o,
   output logic sel_n_o,
   output logic dir_o,
   output logic [1:0] ds_o
);
   localparam int PH = 12; // scl phase kept above 1 us
   // idle: bus released, select high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      sel_n_o = 1'b1;
      dir_o = 1'b1;
      ds_o = 2'h0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt
   ////////////////////////////////////////////////////////////////
   // start: sda falls while scl high
   task automatic start();
      sda_o <= 1'b1;
      wt(PH);
      scl_o <= 1'b1;
      wt(PH);
      sda_o <= 1'b0;
      wt(PH);
      scl_o <= 1'b0;
      wt(PH);
   endtask : start
   // stop: sda rises while scl high, after device release
   task automatic stop();
      sda_o <= 1'b0;
      wt(PH);
      scl_o <= 1'b1;
      wt(PH);
      sda_o <= 1'b1;
      wt(PH);
   endtask : stop
   // one bit: data changes only with scl low
   task automatic bit_io(input logic b, output logic r);
      sda_o <= b;
      wt(PH);
      scl_o <= 1'b1;
      wt(PH);
      r = sda_line_i;
      scl_o <= 1'b0;
      wt(2);
   endtask : bit_io
   // eight bits msb first, then the ninth (acknowledge) clock
   task automatic byte_io(input logic [7:0] w, input logic hack, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], r[i]);
      end
      bit_io(hack, a);
      ack = !a;
   endtask : byte_io
   ////////////////////////////////////////////////////////////////
   // select with scl high, so the select edge is no step
   task automatic ud_sel(input logic [1:0] ch);
      ds_o <= ch;
      sel_n_o <= 1'b0;
      wt(PH);
   endtask : ud_sel
   // n steps, each ends on a scl fall
   task automatic ud_step(input logic dir, input int n);
      dir_o <= dir;
      wt(PH);
      repeat (n) begin
         scl_o <= 1'b1;
         wt(PH);
         scl_o <= 1'b0;
         wt(PH);
      end
   endtask : ud_step
   // deselect, with scl high to store or low to leave it
   task automatic ud_end(input logic st);
      if (st) begin
         scl_o <= 1'b1;
         wt(PH);
      end
      sel_n_o <= 1'b1;
      wt(PH);
      scl_o <= 1'b1;
      wt(PH);
   endtask : ud_end
endmodule : wiper_host
`default_nettype wire

// file: dv/quad_wiper_updown_serial_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module quad_wiper_updown_serial_control_tb_top;
   import quad_wiper_pkg::*;
   localparam logic [3:0] TYPE_ID = 4'ha; // arbitrary value, the design default
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic nrst = 1'b0;
   logic wp_n = 1'b1;
   logic [2:0] hw = 3'h0;
   logic scl, hsda, sel_n, dir, dut_sda, dut_oe_n;
   logic [1:0] ds;
   logic [3:0][7:0] wpos;
   logic [3:0][255:0] tap;
   wire logic sda_line;
   int seed = 32'h976b;
   int fail_count = 0;
   int n_compared = 0;
   int pos [4] = '{128, 128, 128, 128};
   int slot0 [4] = '{128, 128, 128, 128};
   // clocks: core 100 ns, link 48 ns
   always #50 core_clk = ~core_clk;
   always #24 link_clk = ~link_clk;
   // open-drain sda with pull-up
   assign sda_line = hsda & (dut_oe_n | dut_sda);
   ////////////////////////////////////////////////////////////////
   quad_wiper_updown_serial_control i_dut (
      .core_clk_i(core_clk), .nrst_i(nrst), .link_clk_i(link_clk), .scl_i(scl),
      .sda_i(sda_line), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n),
      .interface_select_n_i(sel_n), .count_direction_i(dir), .pot_select_i(ds),
      .nv_write_protect_n_i(wp_n), .hw_address_pins_i(hw), .wiper_position_o(wpos), .tap_sel_o(tap)
   );
   wiper_host i_host (
      .clk_i(core_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(hsda),
      .sel_n_o(sel_n), .dir_o(dir), .ds_o(ds)
   );
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   function automatic int sat(input int v);
      return (v < 0) ? 0 : ((v > 255) ? 255 : v);
   endfunction : sat
   // positions and one-hot taps against the model
   task automatic check_all();
      for (int c = 0; c < 4; c++) begin
         chk("position", 256'(pos[c]), 256'(wpos[c]));
         chk("tap", 256'h1 << pos[c], tap[c]);
      end
   endtask : check_all
   task automatic send(input logic [7:0] w, input logic exp_ack);
      logic [7:0] r;
      logic a;
      i_host.byte_io(w, 1'b1, r, a);
      chk("ack", 256'(exp_ack), 256'(a));
   endtask : send
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic addr_only);
      i_host.start();
      send({TYPE_ID, hw, 1'b0}, 1'b1);
      send({5'h0, a}, 1'b1);
      if (!addr_only) send(d, 1'b1);
      i_host.stop();
      i_host.wt(20);
   endtask : wr
   task automatic rd(input logic [2:0] a, input int e);
      logic [7:0] r;
      logic k;
      wr(a, 8'h00, 1'b1);
      i_host.start();
      send({TYPE_ID, hw, 1'b1}, 1'b1);
      i_host.byte_io(8'hff, 1'b1, r, k);
      i_host.stop();
      i_host.wt(20);
      chk("read data", 256'(e), 256'(r));
   endtask : rd
   // up/down session on one channel, model updated alongside
   task automatic ud(input int c, input int u, input int d, input logic st);
      i_host.ud_sel(2'(c));
      i_host.ud_step(1'b1, u);
      i_host.ud_step(1'b0, d);
      i_host.ud_end(st);
      i_host.wt(20);
      pos[c] = sat(sat(pos[c] + u) - d);
      if (st && wp_n) slot0[c] = pos[c];
   endtask : ud
   ////////////////////////////////////////////////////////////////
   // watchdog for any hang
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      hw <= 3'($random(seed));
      repeat (20) @(posedge core_clk);
      check_all();
      $display("test reset done");
      for (int c = 0; c < 4; c++) ud(c, $random(seed) & 7, $random(seed) & 3, 1'b0);
      check_all();
      ud(3, 130, 0, 1'b0);
      check_all();
      $display("test up down done");
      rd(7, 0);
      wr(0, 8'h02, 1'b0);
      pos[0] = 2;
      check_all();
      ud(0, 0, 5, 1'b0);
      check_all();
      $display("test serial write done");
      ud(1, 3, 0, 1'b1);
      wp_n <= 1'b0;
      ud(2, 2, 0, 1'b1);
      wp_n <= 1'b1;
      wr(7, 8'h01, 1'b0);
      rd(7, 1);
      rd(1, slot0[1]);
      pos[1] = slot0[1];
      rd(2, slot0[2]);
      pos[2] = slot0[2];
      check_all();
      $display("test store done");
      i_host.start();
      send({TYPE_ID, ~hw, 1'b0}, 1'b0);
      i_host.stop();
      i_host.start();
      send({~TYPE_ID, hw, 1'b0}, 1'b0);
      i_host.stop();
      $display("test address match done");
      tally_and_finish();
   end
endmodule : quad_wiper_updown_serial_control_tb_top
`default_nettype wire
